//--- hw/pbesb_pkg.sv
// Package for the bridge error status and bypass control register bank
package pbesb_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] DCS_OFFSET = 8'h00;
  localparam logic [7:0] PCI_ERR_ADDR_OFFSET = 8'h04;
  localparam logic [7:0] BYP_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_W = 8;

  // ****************************************
  // Field positions of the control and status register
  // ****************************************
  localparam int TRANSLATION_BUFFER_ENABLE_BIT = 0;
  localparam int PREFETCH_ENABLE_BIT_BIT = 2;
  localparam int CEI_DIS_BIT = 3;
  localparam int PCD_BIT = 4;
  localparam int RTO_BIT = 5;
  localparam int LOST_BIT = 6;
  localparam int DDP_BIT = 8;
  localparam int IOP_BIT = 9;
  localparam int TAB_BIT = 10;
  localparam int BYP_LO = 16;
  localparam int BYP_HI = 17;

  // ****************************************
  // Reset values and bypass address ranges
  // ****************************************
  localparam logic [31:0] DCS_RESET = 32'h0000_0000;
  localparam logic [31:0] ERR_ADDR_RESET = 32'h0000_0000;
  localparam int FULL_CMP_LO = 6;
  localparam int FULL_CMP_HI = 31;
  localparam int PAGE_CMP_LO = 6;
  localparam int PAGE_CMP_HI = 12;

  // Read bypass modes
  typedef enum logic [1:0] {
    PBESB_BYP_FULL = 2'b00,
    PBESB_BYP_RSVD = 2'b01,
    PBESB_BYP_PART = 2'b10,
    PBESB_BYP_NONE = 2'b11
  } pbesb_byp_t;
endpackage : pbesb_pkg

//--- hw/pbesb_bypass.sv
// Read bypass decision against a buffered DMA write address
`timescale 1ns/1ps
module pbesb_bypass (
  // Mode and addresses
  input wire logic [1:0] mode,
  input wire logic [31:0] rd_addr,
  input wire logic [31:0] wr_addr,
  input wire logic wr_pending,
  // Decision
  output logic bypass_ok
);
  logic full_diff;
  logic page_diff;

  // Compare ranges fixed by the mode
  assign full_diff = rd_addr[pbesb_pkg::FULL_CMP_HI:pbesb_pkg::FULL_CMP_LO]
                   != wr_addr[pbesb_pkg::FULL_CMP_HI:pbesb_pkg::FULL_CMP_LO];
  assign page_diff = rd_addr[pbesb_pkg::PAGE_CMP_HI:pbesb_pkg::PAGE_CMP_LO]
                   != wr_addr[pbesb_pkg::PAGE_CMP_HI:pbesb_pkg::PAGE_CMP_LO];

  // No pending write means nothing to order against
  always_comb begin
    bypass_ok = 1'b0;
    if (!wr_pending) begin
      bypass_ok = 1'b1;
    end else begin
      unique case (pbesb_pkg::pbesb_byp_t'(mode))
        pbesb_pkg::PBESB_BYP_FULL: bypass_ok = full_diff;
        pbesb_pkg::PBESB_BYP_PART: bypass_ok = page_diff;
        pbesb_pkg::PBESB_BYP_NONE: bypass_ok = 1'b0;
        // Reserved code treated as strict ordering, the safe choice
        pbesb_pkg::PBESB_BYP_RSVD: bypass_ok = 1'b0;
      endcase
    end
  end
endmodule : pbesb_bypass

//--- hw/pbesb_err_log.sv
// Error address log with lock on first error
`timescale 1ns/1ps
module pbesb_err_log (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // Capture
  input wire logic err_any,
  input wire logic locked,
  input wire logic [31:0] err_addr,
  // Logged address
  output logic [31:0] addr_q
);
  logic [31:0] addr_r;

  // Captured only while unlocked, so the first error stays valid
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr_r <= pbesb_pkg::ERR_ADDR_RESET;
    end else if (ce && err_any && !locked) begin
      addr_r <= err_addr;
    end
  end

  assign addr_q = addr_r;
endmodule : pbesb_err_log

//--- hw/pbesb_top.sv
// Bridge error status, parity, prefetch, translation and bypass register bank
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module pbesb_top (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // PCI error events, one-cycle pulses with the transaction address
  input wire logic ev_target_abort,
  input wire logic ev_io_parity_raw,
  input wire logic ev_dma_parity_raw,
  input wire logic ev_retry_timeout,
  input wire logic ev_addr_parity_raw,
  input wire logic [31:0] ev_pci_addr,
  // Parity control toward the PCI engine
  output logic parity_check_en,
  output logic parity_gen_en,
  // Prefetch and translation buffer control
  output logic prefetch_en,
  output logic tlb_en,
  input wire logic tlb_alloc_req,
  output logic tlb_alloc_ok,
  output logic tlb_invalidate,
  // Read bypass decision
  input wire logic [31:0] dma_rd_addr,
  input wire logic [31:0] dma_wr_addr,
  input wire logic dma_wr_pending,
  output logic rd_bypass_ok,
  // Error seen when checking is on (diagnostic view)
  output logic addr_parity_err
);
  // ****************************************
  // Register state
  // ****************************************
  logic tab_r;
  logic iop_r;
  logic ddp_r;
  logic lost_r;
  logic rto_r;
  logic pcd_r;
  logic cei_dis_r;
  logic prefetch_enable_bit_r;
  logic translation_buffer_enable_r;
  logic [1:0] byp_r;
  logic [31:0] rdata_r;
  logic addr_par_r;
  logic [31:0] err_addr_q;

  // ****************************************
  // Event qualification
  // ****************************************
  logic io_par_ev;
  logic dma_par_ev;
  logic err_any;
  logic locked;
  logic wr_dcs;
  logic [31:0] w1c;

  // Checks gated off by the disable bit
  assign io_par_ev = ev_io_parity_raw && !pcd_r;
  assign dma_par_ev = ev_dma_parity_raw && !pcd_r;
  assign err_any = ev_target_abort || io_par_ev || dma_par_ev || ev_retry_timeout;

  // Log is locked while any PCI address error flag stands
  assign locked = tab_r || iop_r || ddp_r || rto_r;

  assign wr_dcs = reg_wr && (reg_addr == pbesb_pkg::DCS_OFFSET);
  assign w1c = wr_dcs ? reg_wdata : 32'h0000_0000;

  // ****************************************
  // Error flags: set wins over clear
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tab_r <= 1'b0;
      iop_r <= 1'b0;
      ddp_r <= 1'b0;
      rto_r <= 1'b0;
    end else if (ce) begin
      tab_r <= ev_target_abort || (tab_r && !w1c[pbesb_pkg::TAB_BIT]);
      iop_r <= io_par_ev || (iop_r && !w1c[pbesb_pkg::IOP_BIT]);
      ddp_r <= dma_par_ev || (ddp_r && !w1c[pbesb_pkg::DDP_BIT]);
      rto_r <= ev_retry_timeout || (rto_r && !w1c[pbesb_pkg::RTO_BIT]);
    end
  end

  // Lost flag: a new error while the log already holds one
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lost_r <= 1'b0;
    end else if (ce) begin
      lost_r <= (err_any && locked) || (lost_r && !w1c[pbesb_pkg::LOST_BIT]);
    end
  end

  // Address log; lock keeps the first address
  pbesb_err_log u_log (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .err_any(err_any),
    .locked(locked),
    .err_addr(ev_pci_addr),
    .addr_q(err_addr_q)
  );

  // ****************************************
  // Control fields
  // ****************************************
  // Prefetch bit is write-one-to-toggle per its field type, set by writing a one while clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pcd_r <= 1'b0;
      cei_dis_r <= 1'b0;
      prefetch_enable_bit_r <= 1'b0;
      translation_buffer_enable_r <= 1'b0;
      byp_r <= 2'b00;
    end else if (ce && wr_dcs) begin
      pcd_r <= reg_wdata[pbesb_pkg::PCD_BIT];
      cei_dis_r <= reg_wdata[pbesb_pkg::CEI_DIS_BIT];
      prefetch_enable_bit_r <= reg_wdata[pbesb_pkg::PREFETCH_ENABLE_BIT_BIT] ? !prefetch_enable_bit_r : prefetch_enable_bit_r;
      translation_buffer_enable_r <= reg_wdata[pbesb_pkg::TRANSLATION_BUFFER_ENABLE_BIT];
      byp_r <= reg_wdata[pbesb_pkg::BYP_HI:pbesb_pkg::BYP_LO];
    end
  end

  // Address parity flagged only for visibility, never logged
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr_par_r <= 1'b0;
    end else if (ce) begin
      addr_par_r <= ev_addr_parity_raw && !pcd_r;
    end
  end

  // Control outputs
  assign parity_check_en = !pcd_r;
  assign parity_gen_en = 1'b1;
  assign prefetch_en = prefetch_enable_bit_r;
  assign tlb_en = translation_buffer_enable_r;
  assign tlb_alloc_ok = tlb_alloc_req && translation_buffer_enable_r;
  // Enable bit never drives invalidation; that is a separate register
  assign tlb_invalidate = 1'b0;
  assign addr_parity_err = addr_par_r;

  // ****************************************
  // Read bypass
  // ****************************************
  pbesb_bypass u_byp (
    .mode(byp_r),
    .rd_addr(dma_rd_addr),
    .wr_addr(dma_wr_addr),
    .wr_pending(dma_wr_pending),
    .bypass_ok(rd_bypass_ok)
  );

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  function automatic logic [31:0] dcs_image(
    input logic tab, input logic iop, input logic ddp, input logic lost,
    input logic rto, input logic pcd, input logic cei, input logic prefetch_enable_bit,
    input logic translation_buffer_enable, input logic [1:0] byp);
    logic [31:0] v;
    v = pbesb_pkg::DCS_RESET;
    v[pbesb_pkg::TAB_BIT] = tab;
    v[pbesb_pkg::IOP_BIT] = iop;
    v[pbesb_pkg::DDP_BIT] = ddp;
    v[pbesb_pkg::LOST_BIT] = lost;
    v[pbesb_pkg::RTO_BIT] = rto;
    v[pbesb_pkg::PCD_BIT] = pcd;
    v[pbesb_pkg::CEI_DIS_BIT] = cei;
    v[pbesb_pkg::PREFETCH_ENABLE_BIT_BIT] = prefetch_enable_bit;
    v[pbesb_pkg::TRANSLATION_BUFFER_ENABLE_BIT] = translation_buffer_enable;
    v[pbesb_pkg::BYP_HI:pbesb_pkg::BYP_LO] = byp;
    return v;
  endfunction : dcs_image

  // Unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      rdata_r <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          pbesb_pkg::DCS_OFFSET: rdata_r <= dcs_image(tab_r, iop_r, ddp_r, lost_r, rto_r,
                                                      pcd_r, cei_dis_r, prefetch_enable_bit_r, translation_buffer_enable_r, byp_r);
          pbesb_pkg::PCI_ERR_ADDR_OFFSET: rdata_r <= err_addr_q;
          pbesb_pkg::BYP_STATUS_OFFSET: rdata_r <= {31'h0000_0000, rd_bypass_ok};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_r;
endmodule : pbesb_top

//--- tb/pbesb_sva.sv
// Checker for the bridge error status register bank ports
`timescale 1ns/1ps
module pbesb_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Parity, prefetch and translation control
  input wire logic ev_addr_parity_raw,
  input wire logic parity_check_en,
  input wire logic parity_gen_en,
  input wire logic prefetch_en,
  input wire logic tlb_en,
  input wire logic tlb_alloc_req,
  input wire logic tlb_alloc_ok,
  input wire logic tlb_invalidate,
  input wire logic addr_parity_err,
  // Read bypass
  input wire logic [31:0] dma_rd_addr,
  input wire logic [31:0] dma_wr_addr,
  input wire logic dma_wr_pending,
  input wire logic rd_bypass_ok
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ****************************************
  // Properties
  // ****************************************
  // Control word taken at this edge
  sequence s_ctl_wr;
    ce && reg_wr && reg_addr == 8'h00;
  endsequence
  property p_check; s_ctl_wr |=> parity_check_en == !$past(reg_wdata[4]); endproperty
  property p_gen; parity_gen_en; endproperty
  property p_pref; s_ctl_wr |=> prefetch_en == ($past(prefetch_en) ^ $past(reg_wdata[2])); endproperty
  property p_tlb; s_ctl_wr |=> tlb_en == $past(reg_wdata[0]); endproperty
  property p_alloc; tlb_alloc_ok == (tlb_alloc_req && tlb_en); endproperty
  property p_inval; !tlb_invalidate; endproperty
  // Mask is sampled in the cycle of the pulse, not after it
  property p_mask; ce && ev_addr_parity_raw |=> addr_parity_err == $past(parity_check_en); endproperty
  property p_same; dma_wr_pending && dma_rd_addr[31:6] == dma_wr_addr[31:6] |-> !rd_bypass_ok;
  endproperty
  property p_idle; !dma_wr_pending |-> rd_bypass_ok; endproperty
  property p_rdz; ce && !reg_rd |=> reg_rdata == 32'h0000_0000; endproperty
  a_check: assert property (p_check) else $error("parity check enable wrong");
  a_gen: assert property (p_gen) else $error("parity generation off");
  a_pref: assert property (p_pref) else $error("prefetch enable wrong");
  a_tlb: assert property (p_tlb) else $error("translation enable wrong");
  a_alloc: assert property (p_alloc) else $error("allocation while disabled");
  a_inval: assert property (p_inval) else $error("entries invalidated");
  a_mask: assert property (p_mask) else $error("address parity mask wrong");
  a_same: assert property (p_same) else $error("read passed a matching write");
  a_idle: assert property (p_idle) else $error("read held with no write");
  a_rdz: assert property (p_rdz) else $error("read data outside its cycle");
endmodule : pbesb_sva

bind pbesb_top pbesb_sva u_sva (.ref_clk(ref_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ev_addr_parity_raw(ev_addr_parity_raw), .parity_check_en(parity_check_en),
  .parity_gen_en(parity_gen_en), .prefetch_en(prefetch_en), .tlb_en(tlb_en),
  .tlb_alloc_req(tlb_alloc_req), .tlb_alloc_ok(tlb_alloc_ok), .tlb_invalidate(tlb_invalidate),
  .addr_parity_err(addr_parity_err), .dma_rd_addr(dma_rd_addr), .dma_wr_addr(dma_wr_addr),
  .dma_wr_pending(dma_wr_pending), .rd_bypass_ok(rd_bypass_ok));

//--- tb/pbesb_pci_agent.sv
// Model of the PCI agents that report error events to the bridge
`timescale 1ns/1ps
module pbesb_pci_agent (
  // Clock
  input wire logic ref_clk,
  // Event pulses and transaction address
  output logic [4:0] ev,
  output logic [31:0] ev_addr
);
  initial begin
    ev = 5'h00;
    ev_addr = 32'h0000_0000;
  end
  // One-cycle pulse after a stall; idle address is inverted so stale values never match
  task automatic fire(input int k, input logic [31:0] a, input int dly);
    repeat (dly) @(posedge ref_clk);
    ev[k] <= 1'b1;
    ev_addr <= a;
    @(posedge ref_clk);
    ev <= 5'h00;
    ev_addr <= ~a;
    #1;
  endtask : fire
endmodule : pbesb_pci_agent

//--- tb/tb_pci_bridge_error_status_bypass.sv
// Self-checking bench for the bridge error status register bank
`timescale 1ns/1ps
module tb_pci_bridge_error_status_bypass;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tlb_alloc_req = 1'b0;
  logic pend = 1'b0;
  logic [31:0] rd_a = 32'h0000_0000;
  logic [31:0] wr_a = 32'h0000_0000;
  logic [31:0] reg_rdata, ev_addr, rv;
  logic [4:0] ev;
  logic pce, pge, pfe, tle, tok, tinv, byp, ape;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int bits[4] = '{10, 9, 8, 5};
  always #10 ref_clk = ~ref_clk;
  pbesb_pci_agent agent (.ref_clk(ref_clk), .ev(ev), .ev_addr(ev_addr));
  pbesb_top dut (.ref_clk(ref_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ev_target_abort(ev[0]), .ev_io_parity_raw(ev[1]), .ev_dma_parity_raw(ev[2]),
    .ev_retry_timeout(ev[3]), .ev_addr_parity_raw(ev[4]), .ev_pci_addr(ev_addr),
    .parity_check_en(pce), .parity_gen_en(pge), .prefetch_en(pfe), .tlb_en(tle),
    .tlb_alloc_req(tlb_alloc_req), .tlb_alloc_ok(tok), .tlb_invalidate(tinv),
    .dma_rd_addr(rd_a), .dma_wr_addr(wr_a), .dma_wr_pending(pend), .rd_bypass_ok(byp),
    .addr_parity_err(ape));
  // ****************************************
  // Bus tasks and comparisons
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, rv);
    n_tests++;
    if (rv !== e) begin
      n_fail++;
      $display("unexpected reg %h expected %h seen %h", a, e, rv);
    end
  endtask : rchk
  task automatic bchk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask : bchk
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // Hang guard, well above the roughly 150 cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      summarize();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    rchk(8'h00, 32'h0000_0000);
    rchk(8'h04, 32'h0000_0000);
    rchk(8'h0C, 32'h0000_0000);
    bchk("gen", 1'b1, pge);
    // Log, lose a second error, zero write keeps, one write clears
    foreach (bits[i]) begin
      agent.fire(i, 32'h1000_0040 + i, i);
      rchk(8'h00, 32'h0000_0001 << bits[i]);
      rchk(8'h04, 32'h1000_0040 + i);
      agent.fire(i, 32'h2000_0080, 0);
      rchk(8'h00, (32'h0000_0001 << bits[i]) | 32'h0000_0040);
      rchk(8'h04, 32'h1000_0040 + i);
      wr(8'h00, 32'h0000_0000);
      rchk(8'h00, (32'h0000_0001 << bits[i]) | 32'h0000_0040);
      wr(8'h00, 32'h0000_0760);
      rchk(8'h00, 32'h0000_0000);
    end
    // Checking off: parity events refused, generation untouched
    wr(8'h00, 32'h0000_0018);
    bchk("check_en", 1'b0, pce);
    agent.fire(1, 32'h3000_0000, 0);
    agent.fire(4, 32'h3000_0000, 0);
    bchk("addr_par", 1'b0, ape);
    bchk("gen", 1'b1, pge);
    rchk(8'h00, 32'h0000_0018);
    wr(8'h00, 32'h0000_0000);
    agent.fire(4, 32'h3000_0000, 0);
    bchk("addr_par", 1'b1, ape);
    // Prefetch toggles on a one write; translation enable gates allocation
    wr(8'h00, 32'h0000_0005);
    bchk("prefetch", 1'b1, pfe);
    bchk("tlb", 1'b1, tle);
    @(posedge ref_clk);
    tlb_alloc_req <= 1'b1;
    #1;
    bchk("alloc", 1'b1, tok);
    wr(8'h00, 32'h0000_0004);
    bchk("prefetch", 1'b0, pfe);
    bchk("alloc", 1'b0, tok);
    bchk("inval", 1'b0, tinv);
    // Every bypass mode against same, high-bit and in-page address differences
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'(m) << 16);
      rchk(8'h00, 32'(m) << 16);
      for (int c = 0; c < 3; c++) begin
        @(posedge ref_clk);
        pend <= 1'b1;
        rd_a <= 32'h0012_3440;
        wr_a <= (c == 0) ? 32'h0012_3440 : (c == 1) ? 32'h0002_3440 : 32'h0012_3540;
        #1;
        bchk("bypass", (m == 0 && c != 0) || (m == 2 && c == 2), byp);
      end
    end
    @(posedge ref_clk);
    pend <= 1'b0;
    rchk(8'h08, 32'h0000_0001);
    // Enable low freezes every register: the write and the event are both lost
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(8'h00, 32'h0000_0765);
    agent.fire(0, 32'h4000_0000, 0);
    @(posedge ref_clk);
    ce <= 1'b1;
    rchk(8'h00, 32'h0003_0000);
    rchk(8'h04, 32'h1000_0043);
    summarize();
  end
endmodule : tb_pci_bridge_error_status_bypass
